/* rtl/dtd_decoder.sv */
// data-transfer group decoder: takes opcode then addressing byte
// assumes the fetch queue presents bytes with a valid strobe, same clock
// Functional notes
// - direction bit set: second operand field is destination, else source.
// - size bit set means word operation; clear means byte operation.
// - addressing form 11 makes the locator name a register.
// - extend and size bits both set: one immediate byte, sign-extended.
// - shift count-source bit clear gives a count of exactly one.
// - register codes by size; segment codes 00 extra, 01 code.
// - 10001100 copies segment to operand; 10001110 the reverse.
// - 11010111 is table lookup into the low accumulator byte.
// - 11000101 loads a register and data segment from far pointer.
// - 11000100 loads a register and extra segment from far pointer.
// - accumulator memory moves use low byte or word accumulator by size.
// - locator in register form uses the same register table.
// - displacement: none for 00, one byte for 01, two for 10.
// - form 00 with locator 110 means a direct 16-bit address.
`timescale 1ns/1ps
module dtd_decoder
    import dtd_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // byte stream from fetch queue
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    // decode results
    output logic done_out,
    output logic [3:0] kind_out,
    output logic foreign_out,
    output logic to_sink_out,
    output logic word_out,
    output logic [3:0] reg_sel_out,
    output logic [3:0] rm_sel_out,
    output logic rm_is_reg_out,
    output logic [1:0] seg_sel_out,
    output logic seg_to_operand_out,
    output logic [1:0] disp_len_out,
    output logic direct_addr_out,
    output logic imm_sign_ext_out,
    output logic [1:0] imm_len_out,
    output logic shift_by_one_out,
    output logic [3:0] length_out
);
    // ****************************************
    // state
    // ****************************************
    dtd_state_t state_r, state_nxt;
    logic [7:0] op_r, op_nxt;
    logic done_r, done_nxt;
    logic [3:0] kind_r, kind_nxt;
    logic foreign_r, foreign_nxt;
    logic to_sink_r, to_sink_nxt;
    logic word_r, word_nxt;
    logic [3:0] reg_r, reg_nxt;
    logic [3:0] rm_r, rm_nxt;
    logic rm_is_reg_r, rm_is_reg_nxt;
    logic [1:0] seg_r, seg_nxt;
    logic seg_dir_r, seg_dir_nxt;
    logic [1:0] disp_r, disp_nxt;
    logic direct_r, direct_nxt;
    logic sext_r, sext_nxt;
    logic [1:0] imm_r, imm_nxt;
    logic one_r, one_nxt;
    logic [3:0] len_r, len_nxt;

    dtd_field_if fld();
    dtd_modrm_split u_split (
        .modrm_in(byte_in),
        .fld(fld)
    );

    // ****************************************
    // opcode classification
    // ****************************************
    dtd_kind_t op_kind;
    logic op_has_modrm;
    logic [3:0] op_base_len;
    logic [1:0] op_imm;
    always_comb begin
        op_kind = DTD_K_NONE;
        op_has_modrm = 1'b0;
        op_base_len = 4'h1;
        op_imm = 2'h0;
        if ((byte_in & 8'hfc) == DTD_OP_COPY_RM) begin
            op_kind = DTD_K_COPY;
            op_has_modrm = 1'b1;
        end else if ((byte_in & 8'hfe) == DTD_OP_COPY_IMM_RM) begin
            op_kind = DTD_K_COPY_IMM;
            op_has_modrm = 1'b1;
            op_imm = byte_in[0] ? 2'h2 : 2'h1;
        end else if ((byte_in & 8'hf0) == DTD_OP_COPY_IMM_REG) begin
            op_kind = DTD_K_COPY_IMM;
            op_imm = byte_in[3] ? 2'h2 : 2'h1;
        end else if ((byte_in & 8'hfc) == DTD_OP_ACC_FROM_MEM) begin
            op_kind = DTD_K_ACC_MEM; // covers both directions
            op_base_len = 4'h3;
        end else if (byte_in == DTD_OP_SEG_TO_RM || byte_in == DTD_OP_RM_TO_SEG) begin
            op_kind = DTD_K_SEG_COPY;
            op_has_modrm = 1'b1;
        end else if ((byte_in & 8'hfe) == DTD_OP_EXCH_RM) begin
            op_kind = DTD_K_EXCH;
            op_has_modrm = 1'b1;
        end else if ((byte_in & 8'hf8) == DTD_OP_EXCH_ACC) begin
            op_kind = DTD_K_EXCH;
        end else if (byte_in == DTD_OP_TABLE_LOOKUP) begin
            op_kind = DTD_K_TABLE_LOOKUP;
        end else if (byte_in == DTD_OP_LOAD_EA) begin
            op_kind = DTD_K_LOAD_EA;
            op_has_modrm = 1'b1;
        end else if (byte_in == DTD_OP_FAR_DATA_SEG) begin
            op_kind = DTD_K_FAR_DATA_SEG;
            op_has_modrm = 1'b1;
        end else if (byte_in == DTD_OP_FAR_EXTRA_SEG) begin
            op_kind = DTD_K_FAR_EXTRA_SEG;
            op_has_modrm = 1'b1;
        end else if ((byte_in & 8'hfc) == DTD_OP_SHIFT) begin
            op_kind = DTD_K_SHIFT;
            op_has_modrm = 1'b1;
        end
    end

    // ****************************************
    // next-state decode
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        done_nxt = 1'b0;
        kind_nxt = kind_r;
        foreign_nxt = foreign_r;
        to_sink_nxt = to_sink_r;
        word_nxt = word_r;
        reg_nxt = reg_r;
        rm_nxt = rm_r;
        rm_is_reg_nxt = rm_is_reg_r;
        seg_nxt = seg_r;
        seg_dir_nxt = seg_dir_r;
        disp_nxt = disp_r;
        direct_nxt = direct_r;
        sext_nxt = sext_r;
        imm_nxt = imm_r;
        one_nxt = one_r;
        len_nxt = len_r;
        case (state_r)
            DTD_S_IDLE, DTD_S_DONE: begin
                state_nxt = DTD_S_IDLE;
                if (byte_valid_in) begin
                    op_nxt = byte_in;
                    kind_nxt = op_kind;
                    foreign_nxt = (op_kind == DTD_K_NONE);
                    to_sink_nxt = byte_in[1];
                    word_nxt = byte_in[0];
                    reg_nxt = 4'h0;
                    rm_is_reg_nxt = 1'b0;
                    disp_nxt = 2'h0;
                    direct_nxt = 1'b0;
                    sext_nxt = 1'b0;
                    imm_nxt = op_imm;
                    one_nxt = 1'b0;
                    seg_nxt = DTD_SEG_DATA;
                    seg_dir_nxt = 1'b0;
                    len_nxt = op_base_len + {2'h0, op_imm};
                    if ((byte_in & 8'hf0) == DTD_OP_COPY_IMM_REG) begin
                        word_nxt = byte_in[3];
                        reg_nxt = {byte_in[3], byte_in[2:0]};
                        to_sink_nxt = 1'b1;
                    end else if ((byte_in & 8'hf8) == DTD_OP_EXCH_ACC) begin
                        word_nxt = 1'b1;
                        reg_nxt = {1'b1, byte_in[2:0]};
                        rm_nxt = {1'b1, DTD_REG_ACC};
                        rm_is_reg_nxt = 1'b1;
                    end else if (op_kind == DTD_K_ACC_MEM) begin
                        reg_nxt = {byte_in[0], DTD_REG_ACC};
                        to_sink_nxt = ~byte_in[1];
                        direct_nxt = 1'b1;
                    end else if (op_kind == DTD_K_TABLE_LOOKUP) begin
                        word_nxt = 1'b0;
                        reg_nxt = {1'b0, DTD_REG_ACC};
                        to_sink_nxt = 1'b1;
                    end else if (op_kind == DTD_K_SEG_COPY) begin
                        word_nxt = 1'b1;
                        seg_dir_nxt = ~byte_in[1];
                    end else if (op_kind == DTD_K_FAR_DATA_SEG ||
                                 op_kind == DTD_K_FAR_EXTRA_SEG ||
                                 op_kind == DTD_K_LOAD_EA) begin
                        word_nxt = 1'b1;
                        to_sink_nxt = 1'b1;
                        seg_nxt = byte_in[0] ? DTD_SEG_DATA : DTD_SEG_EXTRA;
                    end else if (op_kind == DTD_K_SHIFT) begin
                        one_nxt = ~byte_in[1];
                    end
                    if (op_has_modrm) begin
                        state_nxt = DTD_S_MODRM;
                    end else begin
                        state_nxt = DTD_S_DONE;
                        done_nxt = 1'b1;
                    end
                end
            end
            DTD_S_MODRM: begin
                if (byte_valid_in) begin
                    rm_is_reg_nxt = fld.loc_is_reg;
                    rm_nxt = {word_r, fld.locator}; // same table as reg field
                    if (kind_r == DTD_K_SEG_COPY) begin
                        seg_nxt = fld.mid[1:0];
                    end else begin
                        reg_nxt = {word_r, fld.mid};
                    end
                    disp_nxt = fld.extra_len[1:0];
                    direct_nxt = fld.direct;
                    // s:w pair on the immediate group shortens the immediate
                    if (kind_r == DTD_K_COPY_IMM && op_r[1:0] == 2'b11) begin
                        sext_nxt = 1'b1;
                        imm_nxt = 2'h1;
                    end
                    len_nxt = 4'h2 + fld.extra_len +
                              {2'h0, (kind_r == DTD_K_COPY_IMM && op_r[1:0] == 2'b11)
                                     ? 2'h1 : imm_r};
                    done_nxt = 1'b1;
                    state_nxt = DTD_S_DONE;
                end
            end
            default: state_nxt = DTD_S_IDLE;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= DTD_S_IDLE;
            op_r <= 8'h00;
            done_r <= 1'b0;
            kind_r <= DTD_K_NONE;
            foreign_r <= 1'b0;
            to_sink_r <= 1'b0;
            word_r <= 1'b0;
            reg_r <= 4'h0;
            rm_r <= 4'h0;
            rm_is_reg_r <= 1'b0;
            seg_r <= DTD_SEG_EXTRA;
            seg_dir_r <= 1'b0;
            disp_r <= 2'h0;
            direct_r <= 1'b0;
            sext_r <= 1'b0;
            imm_r <= 2'h0;
            one_r <= 1'b0;
            len_r <= DTD_LEN_RESET;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            done_r <= done_nxt;
            kind_r <= kind_nxt;
            foreign_r <= foreign_nxt;
            to_sink_r <= to_sink_nxt;
            word_r <= word_nxt;
            reg_r <= reg_nxt;
            rm_r <= rm_nxt;
            rm_is_reg_r <= rm_is_reg_nxt;
            seg_r <= seg_nxt;
            seg_dir_r <= seg_dir_nxt;
            disp_r <= disp_nxt;
            direct_r <= direct_nxt;
            sext_r <= sext_nxt;
            imm_r <= imm_nxt;
            one_r <= one_nxt;
            len_r <= len_nxt;
        end
    end

    assign done_out = done_r;
    assign kind_out = kind_r;
    assign foreign_out = foreign_r;
    assign to_sink_out = to_sink_r;
    assign word_out = word_r;
    assign reg_sel_out = reg_r;
    assign rm_sel_out = rm_r;
    assign rm_is_reg_out = rm_is_reg_r;
    assign seg_sel_out = seg_r;
    assign seg_to_operand_out = seg_dir_r;
    assign disp_len_out = disp_r;
    assign direct_addr_out = direct_r;
    assign imm_sign_ext_out = sext_r;
    assign imm_len_out = imm_r;
    assign shift_by_one_out = one_r;
    assign length_out = len_r;
endmodule

/* rtl/dtd_field_if.sv */
// interface carrying decoded addressing-byte fields
// assumes one producer, the addressing field splitter
`timescale 1ns/1ps
interface dtd_field_if;
    logic [1:0] form;
    logic [2:0] mid;
    logic [2:0] locator;
    logic [3:0] extra_len;
    logic direct;
    logic loc_is_reg;
    modport split (output form, mid, locator, extra_len, direct, loc_is_reg);
    modport use_side (input form, mid, locator, extra_len, direct, loc_is_reg);
endinterface

/* rtl/dtd_modrm_split.sv */
// splits an addressing byte into form, middle field and locator
// assumes the byte is stable in the cycle it is presented
`timescale 1ns/1ps
module dtd_modrm_split
    import dtd_pkg::*;
(
    // addressing byte
    input wire logic [7:0] modrm_in,
    // decoded fields
    dtd_field_if.split fld
);
    // ****************************************
    // field split
    // ****************************************
    always_comb begin
        fld.form = modrm_in[7:6];
        fld.mid = modrm_in[5:3];
        fld.locator = modrm_in[2:0];
        fld.loc_is_reg = (modrm_in[7:6] == DTD_FORM_REG);
        fld.direct = (modrm_in[7:6] == DTD_FORM_NO_DISP) &&
                     (modrm_in[2:0] == DTD_LOC_DIRECT);
        case (modrm_in[7:6])
            DTD_FORM_DISP8: fld.extra_len = 4'h1;
            DTD_FORM_DISP16: fld.extra_len = 4'h2;
            default: fld.extra_len = fld.direct ? 4'h2 : 4'h0;
        endcase
    end
endmodule

/* rtl/dtd_pkg.sv */
// constants and types for the data-transfer group decoder
// assumes opcode bytes arrive from a fetch queue on the processor clock
package dtd_pkg;
    // ****************************************
    // opcode patterns
    // ****************************************
    localparam logic [7:0] DTD_OP_COPY_RM = 8'h88;     // 100010dw
    localparam logic [7:0] DTD_OP_COPY_IMM_RM = 8'hc6; // 1100011w
    localparam logic [7:0] DTD_OP_COPY_IMM_REG = 8'hb0; // 1011wreg
    localparam logic [7:0] DTD_OP_ACC_FROM_MEM = 8'ha0; // 1010000w
    localparam logic [7:0] DTD_OP_ACC_TO_MEM = 8'ha2;   // 1010001w
    localparam logic [7:0] DTD_OP_SEG_TO_RM = 8'h8c;
    localparam logic [7:0] DTD_OP_RM_TO_SEG = 8'h8e;
    localparam logic [7:0] DTD_OP_EXCH_RM = 8'h86;     // 1000011w
    localparam logic [7:0] DTD_OP_EXCH_ACC = 8'h90;    // 10010reg
    localparam logic [7:0] DTD_OP_TABLE_LOOKUP = 8'hd7;
    localparam logic [7:0] DTD_OP_LOAD_EA = 8'h8d;
    localparam logic [7:0] DTD_OP_FAR_DATA_SEG = 8'hc5;
    localparam logic [7:0] DTD_OP_FAR_EXTRA_SEG = 8'hc4;
    localparam logic [7:0] DTD_OP_SHIFT = 8'hd0;       // 110100vw
    // ****************************************
    // field values
    // ****************************************
    localparam logic [1:0] DTD_FORM_NO_DISP = 2'h0;
    localparam logic [1:0] DTD_FORM_DISP8 = 2'h1;
    localparam logic [1:0] DTD_FORM_DISP16 = 2'h2;
    localparam logic [1:0] DTD_FORM_REG = 2'h3;
    localparam logic [2:0] DTD_LOC_DIRECT = 3'h6;
    localparam logic [2:0] DTD_REG_ACC = 3'h0;
    localparam logic [2:0] DTD_REG_COUNT = 3'h1;
    localparam logic [1:0] DTD_SEG_EXTRA = 2'h0;
    localparam logic [1:0] DTD_SEG_CODE = 2'h1;
    localparam logic [1:0] DTD_SEG_DATA = 2'h3;
    localparam logic [3:0] DTD_LEN_RESET = 4'h0;

    typedef enum logic [3:0] {
        DTD_K_NONE = 4'h0, DTD_K_COPY = 4'h1, DTD_K_COPY_IMM = 4'h2,
        DTD_K_ACC_MEM = 4'h3, DTD_K_SEG_COPY = 4'h4, DTD_K_EXCH = 4'h5,
        DTD_K_TABLE_LOOKUP = 4'h6, DTD_K_LOAD_EA = 4'h7,
        DTD_K_FAR_DATA_SEG = 4'h8, DTD_K_FAR_EXTRA_SEG = 4'h9,
        DTD_K_SHIFT = 4'ha
    } dtd_kind_t;

    typedef enum logic [1:0] {
        DTD_S_IDLE = 2'b00, DTD_S_MODRM = 2'b01, DTD_S_DONE = 2'b11
    } dtd_state_t;
endpackage

/* verification/data_transfer_decoder_tb.sv */
// self-checking bench for the data-transfer decoder
// assumes the fetch model supplies opcode and addressing bytes only
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module data_transfer_decoder_tb
    import dtd_pkg::*;
;
    // ****
    // signals
    // ****
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic slow = 1'b0;
    logic vld, done, foreign, to_sink, word, rm_is_reg, seg_to_op, direct, imm_sext, shift_one;
    logic [7:0] bt;
    logic [3:0] kind, reg_sel, rm_sel, length;
    logic [1:0] seg_sel, disp_len, imm_len;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 32'hea36;
    int exp_q[$];
    int dir[] = '{16'h88c1, 16'h8b06, 16'h8947, 16'h8a80, 16'h8bc8, 16'hc600, 16'hc7c0,
        16'hb000, 16'hbf00, 16'ha000, 16'ha300, 16'h8cd8, 16'h8e08, 16'hd700, 16'hc536,
        16'hc447, 16'h8d86, 16'h86c8, 16'h9100, 16'hd0e0, 16'hd3e1, 16'hd2c0, 16'h8f00,
        16'hff00, 16'h0000, 16'he400};

    always #5 clk_in = ~clk_in;

    dtd_fetch_model u_fetch (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
        .byte_valid_out(vld), .byte_out(bt));
    dtd_decoder u_dut (.clk_in(clk_in), .rst_in(rst_in), .byte_valid_in(vld), .byte_in(bt),
        .done_out(done), .kind_out(kind), .foreign_out(foreign), .to_sink_out(to_sink),
        .word_out(word), .reg_sel_out(reg_sel), .rm_sel_out(rm_sel),
        .rm_is_reg_out(rm_is_reg), .seg_sel_out(seg_sel), .seg_to_operand_out(seg_to_op),
        .disp_len_out(disp_len), .direct_addr_out(direct), .imm_sign_ext_out(imm_sext),
        .imm_len_out(imm_len), .shift_by_one_out(shift_one), .length_out(length));

    // ****
    // reference model
    // ****
    function automatic int has_rm(input int op);
        return (op >= 8'h86 && op <= 8'h8e) || (op >= 8'hc4 && op <= 8'hc7)
            || (op >= 8'hd0 && op <= 8'hd3);
    endfunction

    function automatic int kind_of(input int op);
        if (op >= 8'h88 && op <= 8'h8b) return 1;
        if (op == 8'hc6 || op == 8'hc7 || (op >= 8'hb0 && op <= 8'hbf)) return 2;
        if (op >= 8'ha0 && op <= 8'ha3) return 3;
        if (op == 8'h8c || op == 8'h8e) return 4;
        if (op == 8'h86 || op == 8'h87 || (op >= 8'h90 && op <= 8'h97)) return 5;
        if (op == 8'hd7) return 6;
        if (op == 8'h8d) return 7;
        if (op == 8'hc5) return 8;
        if (op == 8'hc4) return 9;
        if (op >= 8'hd0 && op <= 8'hd3) return 10;
        return 0;
    endfunction

    task automatic check_one(input int v);
        int op, rm, k, w, md, lc, dl, im;
        op = v >> 8;
        rm = v & 255;
        k = kind_of(op);
        w = (k == 2 && op < 8'hc0) ? (op >> 3) & 1 : op & 1;
        md = rm >> 6;
        lc = rm & 7;
        // acc-mem address bytes count in length, not as displacement
        dl = has_rm(op) == 0 ? 0 : md == 1 ? 1
            : (md == 2 || (md == 0 && lc == 6)) ? 2 : 0;
        im = (k != 2) ? 0 : (op < 8'hc0) ? w + 1 : 1;
        `CHK(kind, 4'(k))
        `CHK(foreign, k == 0)
        if (k == 0) return;
        `CHK(length, 4'(1 + has_rm(op) + dl + im + (k == 3 ? 2 : 0)))
        `CHK(disp_len, 2'(dl))
        `CHK(imm_len, 2'(im))
        `CHK(direct, k == 3 || (has_rm(op) != 0 && md == 0 && lc == 6))
        if (has_rm(op) != 0) `CHK(rm_is_reg, md == 3)
        if (k >= 1 && k <= 3) `CHK(word, 1'(w))
        if (k == 1) `CHK(to_sink, 1'((op >> 1) & 1))
        if (k == 1) `CHK(reg_sel, 4'(w * 8 + ((rm >> 3) & 7)))
        if (k == 1 && md == 3) `CHK(rm_sel, 4'(w * 8 + lc))
        if (k == 3) `CHK(reg_sel, 4'(w * 8))
        if (k == 4) `CHK(seg_sel, 2'(rm >> 3))
        if (k == 4) `CHK(seg_to_op, op == 8'h8c)
        if (k == 6) `CHK(reg_sel, 4'h0)
        if (k == 8 || k == 9) `CHK(seg_sel, k == 8 ? 2'h3 : 2'h0)
        if (k == 8 || k == 9) `CHK(to_sink, 1'b1)
        if (k == 2 && op >= 8'hc0) `CHK(imm_sext, 1'(op & 1))
        if (k == 10) `CHK(shift_one, ((op >> 1) & 1) == 0)
    endtask

    // ****
    // stimulus and checking
    // ****
    task automatic send(input int op, input int rm);
        u_fetch.push(op[7:0]);
        if (has_rm(op) != 0) u_fetch.push(rm[7:0]);
        exp_q.push_back(op * 256 + rm);
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 5000 && exp_q.size() > 0; n++) @(posedge clk_in);
        repeat (3) @(posedge clk_in);
        `CHK(exp_q.size(), 0)
    endtask

    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(negedge clk_in) begin
        if (!rst_in && done === 1'b1) begin
            if (exp_q.size() == 0) `CHK(done, 1'b0)
            else check_one(exp_q.pop_front());
        end
    end

    initial begin
        repeat (3) @(posedge clk_in);
        #1 rst_in = 1'b0;
        `CHK(length, DTD_LEN_RESET)
        `CHK(seg_sel, 2'h0)
        foreach (dir[i]) send(dir[i] >> 8, dir[i] & 255);
        wait_idle();
        slow = 1'b1;
        repeat (300) send($random(seed) & 255, $random(seed) & 255);
        wait_idle();
        final_report();
    end

    // watchdog at 20000 cycles, well beyond the several hundred cycles the sequence needs
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule

/* verification/dtd_decoder_asserts.sv */
// timing and field checks on the decoder ports
// assumes binding to dtd_decoder, single clock domain
`timescale 1ns/1ps
module dtd_decoder_chk (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // byte stream
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    // results
    input wire logic done_out,
    input wire logic [3:0] kind_out,
    input wire logic foreign_out,
    input wire logic to_sink_out,
    input wire logic word_out,
    input wire logic [3:0] reg_sel_out,
    input wire logic rm_is_reg_out,
    input wire logic [1:0] seg_sel_out,
    input wire logic seg_to_operand_out,
    input wire logic [1:0] disp_len_out,
    input wire logic direct_addr_out,
    input wire logic shift_by_one_out,
    input wire logic [3:0] length_out
);
    // ****
    // helper tracking of opcode and addressing byte
    // ****
    logic wait_rm_r;
    logic from_rm_r;
    logic [7:0] op_r;
    logic [7:0] modrm_r;
    logic last_w;

    function automatic logic has_rm(input logic [7:0] b);
        return (b >= 8'h86 && b <= 8'h8e) || b[7:2] == 6'h31 || b[7:2] == 6'h34;
    endfunction

    assign last_w = byte_valid_in && !rst_in && (wait_rm_r || !has_rm(byte_in));

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_rm_r <= 1'b0;
            from_rm_r <= 1'b0;
            op_r <= 8'h00;
            modrm_r <= 8'h00;
        end else begin
            from_rm_r <= byte_valid_in && wait_rm_r;
            if (byte_valid_in && wait_rm_r) begin
                modrm_r <= byte_in;
                wait_rm_r <= 1'b0;
            end else if (byte_valid_in) begin
                op_r <= byte_in;
                wait_rm_r <= has_rm(byte_in);
            end
        end
    end

    // ****
    // assertions
    // ****
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_done_exact: assert property (done_out == $past(last_w))
        else $error("done pulse misplaced");
    a_table_lookup: assert property (byte_valid_in && !wait_rm_r && byte_in == 8'hd7
        |=> done_out && kind_out == 4'h6 && length_out == 4'h1) else $error("lookup decode");
    a_foreign_flag: assert property (done_out |-> foreign_out == (kind_out == 4'h0))
        else $error("foreign flag");
    a_form_reg: assert property (done_out && from_rm_r
        |-> rm_is_reg_out == (modrm_r[7:6] == 2'h3)) else $error("register form");
    a_disp_len: assert property (done_out && from_rm_r && modrm_r[7:6] != 2'h0
        |-> disp_len_out == (modrm_r[7:6] == 2'h3 ? 2'h0 : modrm_r[7:6])) else $error("disp");
    a_direct_addr: assert property (done_out && from_rm_r
        |-> direct_addr_out == (modrm_r[7:6] == 2'h0 && modrm_r[2:0] == 3'h6))
        else $error("direct address");
    a_copy_dir: assert property (done_out && op_r[7:2] == 6'h22
        |-> to_sink_out == op_r[1] && word_out == op_r[0]
        && reg_sel_out == {op_r[0], modrm_r[5:3]}) else $error("copy fields");
    a_seg_copy: assert property (done_out && (op_r == 8'h8c || op_r == 8'h8e)
        |-> seg_sel_out == modrm_r[4:3] && seg_to_operand_out == !op_r[1])
        else $error("segment copy");
    a_far_seg: assert property (done_out && op_r[7:1] == 7'h62
        |-> to_sink_out && seg_sel_out == (op_r[0] ? 2'h3 : 2'h0)) else $error("far load");
    a_shift_one: assert property (done_out && op_r[7:2] == 6'h34
        |-> shift_by_one_out == !op_r[1]) else $error("shift count");
endmodule

bind dtd_decoder dtd_decoder_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
    .byte_valid_in(byte_valid_in), .byte_in(byte_in), .done_out(done_out),
    .kind_out(kind_out), .foreign_out(foreign_out), .to_sink_out(to_sink_out),
    .word_out(word_out), .reg_sel_out(reg_sel_out), .rm_is_reg_out(rm_is_reg_out),
    .seg_sel_out(seg_sel_out), .seg_to_operand_out(seg_to_operand_out),
    .disp_len_out(disp_len_out), .direct_addr_out(direct_addr_out),
    .shift_by_one_out(shift_by_one_out), .length_out(length_out));

/* verification/dtd_fetch_model.sv */
// fetch queue model feeding opcode and addressing bytes to the decoder
// assumes the bench pushes only the bytes that the decoder consumes
`timescale 1ns/1ps
module dtd_fetch_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // pacing: high lets the queue stall at random
    input wire logic slow_in,
    // byte stream toward the decoder
    output logic byte_valid_out,
    output logic [7:0] byte_out
);
    // ****
    // queue and pacing
    // ****
    logic [7:0] q[$];
    int seed = 32'hea36;

    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask

    initial begin
        byte_valid_out = 1'b0;
        byte_out = 8'h00;
    end

    // idle cycles show the inverted byte, so a stale value never looks valid
    always @(posedge clk_in) begin
        #1;
        if (!rst_in && q.size() > 0 && !(slow_in && $random(seed) % 3 == 0)) begin
            byte_valid_out <= 1'b1;
            byte_out <= q.pop_front();
        end else begin
            byte_valid_out <= 1'b0;
            byte_out <= ~byte_out;
        end
    end
endmodule
